// ===== design/rwu_pkg.sv
package rwu_pkg;
    // bus
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam logic [7:0]  ADDR_WDT_RESTART = 8'he3;
    localparam logic [7:0]  ADDR_SYS_SC     = 8'hff;
    localparam logic [7:0]  ADDR_IRQ_STAT   = 8'hf0;
    localparam logic [7:0]  ADDR_IRQ_MASK   = 8'hf1;
    localparam logic [7:0]  ADDR_OSC_CTRL   = 8'hf2;
    localparam logic [7:0]  RESTART_BOTH    = 8'h38;
    localparam logic [7:0]  SYS_SC_RESET    = 8'h10;
    localparam logic [7:0]  ZERO_BYTE       = 8'h00;
    localparam logic [7:0]  RESET_VECTOR    = 8'h00;
    // status/control field positions
    localparam int          SC_IRQEN        = 7;
    localparam int          SC_WDOG         = 5;
    localparam int          SC_PWRON        = 4;
    localparam int          SC_SLEEP        = 3;
    localparam int          SC_STOP         = 0;
    // interrupt status bits
    localparam int          IRQ_W           = 2;
    localparam int          IRQ_SLEEP_OVF   = 0;
    localparam int          IRQ_HOLD_DONE   = 1;
    // timing
    localparam longint      CLK_HZ          = 200_000_000;
    localparam longint      CLK_PERIOD_NS   = 5;
    localparam longint      LP_OSC_HZ       = 32_000;
    localparam longint      HOLD_NS         = 20_000_000;
    localparam int          HOLD_CYCLES     =
        int'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int          TICK_DIV        = int'(CLK_HZ / LP_OSC_HZ);
    localparam int          HOLD_W          = 23;
    localparam int          DIV_W           = 16;
    // sleep timer last counts in low-power oscillator ticks; each period is one tick longer
    localparam int          SLP_W           = 15;
    localparam logic [14:0] SLP_P0          = 15'h003f;
    localparam logic [14:0] SLP_P1          = 15'h01ff;
    localparam logic [14:0] SLP_P2          = 15'h0fff;
    localparam logic [14:0] SLP_P3          = 15'h7fff;
    localparam logic [1:0]  WDT_LAST        = 2'h2;
endpackage

// ===== design/rwu_timer_if.sv
`timescale 1ns/1ps
interface rwu_timer_if;
    logic       soft_rst;
    logic       wdt_en;
    logic [1:0] period_sel;
    logic       clr_wdt;
    logic       clr_sleep;
    logic       overflow;
    logic       wdt_fire;
    logic [1:0] wdt_count;
    modport ctrl  (output soft_rst, wdt_en, period_sel, clr_wdt, clr_sleep,
                   input overflow, wdt_fire, wdt_count);
    modport timer (input soft_rst, wdt_en, period_sel, clr_wdt, clr_sleep,
                   output overflow, wdt_fire, wdt_count);
endinterface

// ===== design/rwu_timers.sv
`timescale 1ns/1ps
module rwu_timers #(
    parameter int TICK_DIV = rwu_pkg::TICK_DIV
) (
    input  wire logic   clk_in,
    rwu_timer_if.timer  tif
);
    logic [rwu_pkg::DIV_W-1:0] div_q;
    logic [rwu_pkg::SLP_W-1:0] slp_q;
    logic [rwu_pkg::SLP_W-1:0] period;
    logic [1:0]                wdt_q;
    logic                      tick;
    logic                      ovf;

    // low-power oscillator tick as one-cycle enable
    assign tick = (div_q == rwu_pkg::DIV_W'(TICK_DIV - 1));
    always_ff @(posedge clk_in) begin
        if (tif.soft_rst || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // period select
    always_comb begin
        unique case (tif.period_sel)
            2'h0: period = rwu_pkg::SLP_P0;
            2'h1: period = rwu_pkg::SLP_P1;
            2'h2: period = rwu_pkg::SLP_P2;
            2'h3: period = rwu_pkg::SLP_P3;
        endcase
    end

    // sleep timer counts oscillator ticks
    assign ovf = tick && (slp_q >= period);
    always_ff @(posedge clk_in) begin
        if (tif.soft_rst || tif.clr_sleep) begin
            slp_q <= '0;
        end else if (ovf) begin
            slp_q <= '0;
        end else if (tick) begin
            slp_q <= slp_q + 1'b1;
        end
    end

    // watchdog counter advances on overflows
    always_ff @(posedge clk_in) begin
        if (tif.soft_rst || tif.clr_wdt) begin
            wdt_q <= '0;
        end else if (tif.wdt_en && ovf) begin
            wdt_q <= (wdt_q == rwu_pkg::WDT_LAST) ? 2'h0 : wdt_q + 1'b1;
        end
    end

    assign tif.overflow  = ovf;
    assign tif.wdt_fire  = tif.wdt_en && ovf && !tif.clr_wdt &&
                           (wdt_q == rwu_pkg::WDT_LAST);
    assign tif.wdt_count = wdt_q;
endmodule

// ===== design/rwu_top.sv
`timescale 1ns/1ps
module rwu_top #(
    parameter int HOLD_CYCLES = rwu_pkg::HOLD_CYCLES,
    parameter int TICK_DIV    = rwu_pkg::TICK_DIV
) (
    // clock and reset
    input  wire logic                       CLK_IN,
    input  wire logic                       RESETN_IN,
    // supply and processor status
    input  wire logic                       SUPPLY_LOW_IN,
    input  wire logic                       GLOBAL_IRQ_ENABLE_IN,
    input  wire logic                       IRQ_PENDING_IN,
    // register port
    input  wire logic [rwu_pkg::ADDR_W-1:0] ADDR_IN,
    input  wire logic [rwu_pkg::DATA_W-1:0] WDATA_IN,
    input  wire logic                       WR_IN,
    input  wire logic                       RD_IN,
    output logic      [rwu_pkg::DATA_W-1:0] RDATA_OUT,
    // processor control
    output logic                            CPU_HOLD_OUT,
    output logic      [7:0]                 RESET_VECTOR_OUT,
    output logic                            CPU_SLEEP_OUT,
    output logic                            CPU_STOP_OUT,
    output logic                            WATCHDOG_RESET_EVENT_OUT,
    output logic                            SLEEP_TIMER_IRQ_OUT,
    output logic                            IRQ_OUT
);
    rwu_timer_if tif ();

    logic                       por_event;
    logic                       wdog_rst_q;
    logic                       any_rst;
    logic                       wr_sc;
    logic                       wr_restart;
    logic                       wr_stat;
    logic                       wr_mask;
    logic                       wr_osc;
    logic                       pwr_flag_q;
    logic                       wdog_flag_q;
    logic                       sleep_q;
    logic                       stop_q;
    logic                       wdt_en_q;
    logic                       hold_q;
    logic [rwu_pkg::HOLD_W-1:0] hold_cnt_q;
    logic [1:0]                 osc_sel_q;
    logic [rwu_pkg::IRQ_W-1:0]  irq_stat_q;
    logic [rwu_pkg::IRQ_W-1:0]  irq_mask_q;
    logic [rwu_pkg::IRQ_W-1:0]  irq_evt;
    logic                       hold_done;
    logic [7:0]                 sc_view;
    logic [7:0]                 rdata_d;
    logic [7:0]                 rdata_q;

    // reset sources
    assign por_event = !RESETN_IN || SUPPLY_LOW_IN;
    assign any_rst   = por_event || wdog_rst_q;

    // write decode
    assign wr_sc      = WR_IN && (ADDR_IN == rwu_pkg::ADDR_SYS_SC);
    assign wr_restart = WR_IN && (ADDR_IN == rwu_pkg::ADDR_WDT_RESTART);
    assign wr_stat    = WR_IN && (ADDR_IN == rwu_pkg::ADDR_IRQ_STAT);
    assign wr_mask    = WR_IN && (ADDR_IN == rwu_pkg::ADDR_IRQ_MASK);
    assign wr_osc     = WR_IN && (ADDR_IN == rwu_pkg::ADDR_OSC_CTRL);

    // watchdog reset pulse, one cycle after the counter fires
    always_ff @(posedge CLK_IN) begin
        if (por_event) begin
            wdog_rst_q <= 1'b0;
        end else begin
            wdog_rst_q <= tif.wdt_fire;
        end
    end

    // power-on flag: set by power-on only, firmware may clear
    always_ff @(posedge CLK_IN) begin
        if (por_event) begin
            pwr_flag_q <=
                rwu_pkg::SYS_SC_RESET[rwu_pkg::SC_PWRON];
        end else if (wdog_rst_q) begin
            pwr_flag_q <= 1'b0;
        end else if (wr_sc && !WDATA_IN[rwu_pkg::SC_PWRON]) begin
            pwr_flag_q <= 1'b0;
        end
    end

    // watchdog reset flag: set by watchdog reset, firmware may clear
    always_ff @(posedge CLK_IN) begin
        if (por_event) begin
            wdog_flag_q <= rwu_pkg::SYS_SC_RESET[rwu_pkg::SC_WDOG];
        end else if (wdog_rst_q) begin
            wdog_flag_q <= 1'b1;
        end else if (wr_sc && !WDATA_IN[rwu_pkg::SC_WDOG]) begin
            wdog_flag_q <= 1'b0;
        end
    end

    // watchdog enable: only a power-on disables it
    always_ff @(posedge CLK_IN) begin
        if (por_event) begin
            wdt_en_q <= 1'b0;
        end else if (wr_sc && pwr_flag_q &&
                     !WDATA_IN[rwu_pkg::SC_PWRON]) begin
            wdt_en_q <= 1'b1;
        end
    end

    // sleep and stop bits
    always_ff @(posedge CLK_IN) begin
        if (any_rst) begin
            sleep_q <= rwu_pkg::SYS_SC_RESET[rwu_pkg::SC_SLEEP];
            stop_q  <= rwu_pkg::SYS_SC_RESET[rwu_pkg::SC_STOP];
        end else begin
            if (wr_sc) begin
                sleep_q <= WDATA_IN[rwu_pkg::SC_SLEEP];
                stop_q  <= WDATA_IN[rwu_pkg::SC_STOP];
            end else if (IRQ_PENDING_IN || IRQ_OUT) begin
                sleep_q <= 1'b0;
            end
        end
    end

    // processor hold-off after power-on
    assign hold_done = hold_q &&
        (hold_cnt_q == rwu_pkg::HOLD_W'(HOLD_CYCLES - 1));
    always_ff @(posedge CLK_IN) begin
        if (por_event) begin
            hold_q     <= 1'b1;
            hold_cnt_q <= '0;
        end else if (hold_done) begin
            hold_q     <= 1'b0;
        end else if (hold_q) begin
            hold_cnt_q <= hold_cnt_q + 1'b1;
        end
    end

    // sleep period select
    always_ff @(posedge CLK_IN) begin
        if (any_rst) begin
            osc_sel_q <= '0;
        end else if (wr_osc) begin
            osc_sel_q <= WDATA_IN[1:0];
        end
    end

    // interrupt status, mask and output
    assign irq_evt[rwu_pkg::IRQ_SLEEP_OVF] = tif.overflow;
    assign irq_evt[rwu_pkg::IRQ_HOLD_DONE] = hold_done;
    always_ff @(posedge CLK_IN) begin
        if (any_rst) begin
            irq_mask_q <= '0;
        end else if (wr_mask) begin
            irq_mask_q <= WDATA_IN[rwu_pkg::IRQ_W-1:0];
        end
    end
    always_ff @(posedge CLK_IN) begin
        if (any_rst) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= irq_evt | (irq_stat_q &
                ~(wr_stat ? WDATA_IN[rwu_pkg::IRQ_W-1:0] : '0));
        end
    end
    assign IRQ_OUT = |(irq_stat_q & irq_mask_q);

    // timers
    assign tif.soft_rst   = any_rst;
    assign tif.wdt_en     = wdt_en_q;
    assign tif.period_sel = osc_sel_q;
    assign tif.clr_wdt    = wr_restart;
    assign tif.clr_sleep  = wr_restart &&
                            (WDATA_IN == rwu_pkg::RESTART_BOTH);

    rwu_timers #(
        .TICK_DIV (TICK_DIV)
    ) u_timers (
        .clk_in (CLK_IN),
        .tif    (tif)
    );

    // read view of status/control
    always_comb begin
        sc_view                   = rwu_pkg::ZERO_BYTE;
        sc_view[rwu_pkg::SC_IRQEN] = GLOBAL_IRQ_ENABLE_IN;
        sc_view[rwu_pkg::SC_WDOG]  = wdog_flag_q;
        sc_view[rwu_pkg::SC_PWRON] = pwr_flag_q;
        sc_view[rwu_pkg::SC_SLEEP] = sleep_q;
        sc_view[rwu_pkg::SC_STOP]  = stop_q;
    end

    // read mux; restart register and unmapped addresses read zero
    always_comb begin
        rdata_d = rwu_pkg::ZERO_BYTE;
        unique case (ADDR_IN)
            rwu_pkg::ADDR_SYS_SC:   rdata_d = sc_view;
            rwu_pkg::ADDR_IRQ_STAT: rdata_d = {6'h00, irq_stat_q};
            rwu_pkg::ADDR_IRQ_MASK: rdata_d = {6'h00, irq_mask_q};
            rwu_pkg::ADDR_OSC_CTRL: rdata_d = {tif.wdt_count, 4'h0, osc_sel_q};
            default:                rdata_d = rwu_pkg::ZERO_BYTE;
        endcase
    end
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            rdata_q <= rwu_pkg::ZERO_BYTE;
        end else if (RD_IN) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= rwu_pkg::ZERO_BYTE;
        end
    end

    // outputs
    assign RDATA_OUT                = rdata_q;
    assign CPU_HOLD_OUT             = hold_q || wdog_rst_q;
    assign RESET_VECTOR_OUT         = rwu_pkg::RESET_VECTOR;
    assign CPU_SLEEP_OUT            = sleep_q;
    assign CPU_STOP_OUT             = stop_q;
    assign WATCHDOG_RESET_EVENT_OUT = wdog_rst_q;
    assign SLEEP_TIMER_IRQ_OUT      = tif.overflow;
endmodule

// ===== dv/rwu_top_asserts.sv
`timescale 1ns/1ps
module rwu_top_asserts #(
    parameter int HOLD_CYCLES = rwu_pkg::HOLD_CYCLES
) (
    // clock, reset, supply, pending interrupt
    input wire logic       CLK_IN,
    input wire logic       RESETN_IN,
    input wire logic       SUPPLY_LOW_IN,
    input wire logic       IRQ_PENDING_IN,
    // register port
    input wire logic [7:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic       WR_IN,
    input wire logic       RD_IN,
    input wire logic [7:0] RDATA_OUT,
    // processor control
    input wire logic       CPU_HOLD_OUT,
    input wire logic [7:0] RESET_VECTOR_OUT,
    input wire logic       CPU_SLEEP_OUT,
    input wire logic       CPU_STOP_OUT,
    input wire logic       WATCHDOG_RESET_EVENT_OUT,
    input wire logic       SLEEP_TIMER_IRQ_OUT,
    input wire logic       IRQ_OUT
);
    int cnt_q;
    // cycles since power-on release, saturating
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN || SUPPLY_LOW_IN) cnt_q <= 0;
        else if (cnt_q < HOLD_CYCLES + 4) cnt_q <= cnt_q + 1;
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN || SUPPLY_LOW_IN);
    // firmware write of status/control, no watchdog reset beside it
    sequence sc_wr;
        WR_IN && ADDR_IN == 8'hff && !WATCHDOG_RESET_EVENT_OUT;
    endsequence
    sequence wdog_rst_start;
        $rose(WATCHDOG_RESET_EVENT_OUT);
    endsequence
    AST_VECTOR: assert property (RESET_VECTOR_OUT == 8'h00)
        else $error("start address not zero");
    AST_HOLD_RUNS: assert property (
        cnt_q < HOLD_CYCLES - 1 |-> CPU_HOLD_OUT)
        else $error("processor released too early");
    AST_HOLD_ENDS: assert property (
        cnt_q == HOLD_CYCLES + 2 |-> !CPU_HOLD_OUT)
        else $error("processor still held");
    AST_RDATA_IDLE: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
        else $error("read data without read");
    AST_RESTART_WO: assert property (
        RD_IN && ADDR_IN == 8'he3 |=> RDATA_OUT == 8'h00)
        else $error("restart register readable");
    AST_WDOG_PULSE: assert property (
        WATCHDOG_RESET_EVENT_OUT |=> !WATCHDOG_RESET_EVENT_OUT)
        else $error("watchdog reset longer than one cycle");
    AST_WDOG_CAUSE: assert property (
        wdog_rst_start |-> $past(SLEEP_TIMER_IRQ_OUT))
        else $error("watchdog reset without overflow");
    AST_OVF_PULSE: assert property (
        SLEEP_TIMER_IRQ_OUT |=> !SLEEP_TIMER_IRQ_OUT)
        else $error("sleep overflow longer than one cycle");
    AST_WDOG_CLEARS: assert property (WATCHDOG_RESET_EVENT_OUT |=>
        !CPU_SLEEP_OUT && !CPU_STOP_OUT && !IRQ_OUT)
        else $error("state kept over watchdog reset");
    AST_SC_WRITE: assert property (sc_wr |=>
        CPU_SLEEP_OUT == $past(WDATA_IN[3]) &&
        CPU_STOP_OUT == $past(WDATA_IN[0]))
        else $error("sleep or stop bit not written");
    AST_WAKE: assert property (CPU_SLEEP_OUT && IRQ_PENDING_IN &&
        !(WR_IN && ADDR_IN == 8'hff) |=> !CPU_SLEEP_OUT)
        else $error("no wake on pending interrupt");
endmodule

// ===== dv/rwu_top_tb.sv
`timescale 1ns/1ps
module rwu_top_tb;
    logic       clk_in, resetn_in, supply_low_in, irq_en_in, irq_pend_in;
    logic       wr_in, rd_in, hold_out, sleep_out, stop_out;
    logic       wdog_out, ovf_out, irq_out;
    logic [7:0] addr_in, wdata_in, rdata_out, vec_out;
    int         num_errors = 0, total_checks = 0, cyc = 0;
    int         ovf_n = 0, wdog_n = 0, k, w, n;
    rwu_top #(.HOLD_CYCLES(20), .TICK_DIV(4)) dut_u (
        .CLK_IN(clk_in), .RESETN_IN(resetn_in),
        .SUPPLY_LOW_IN(supply_low_in), .GLOBAL_IRQ_ENABLE_IN(irq_en_in),
        .IRQ_PENDING_IN(irq_pend_in), .ADDR_IN(addr_in),
        .WDATA_IN(wdata_in), .WR_IN(wr_in), .RD_IN(rd_in),
        .RDATA_OUT(rdata_out), .CPU_HOLD_OUT(hold_out),
        .RESET_VECTOR_OUT(vec_out), .CPU_SLEEP_OUT(sleep_out),
        .CPU_STOP_OUT(stop_out), .WATCHDOG_RESET_EVENT_OUT(wdog_out),
        .SLEEP_TIMER_IRQ_OUT(ovf_out), .IRQ_OUT(irq_out));
    // 200 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    // cycle and event counts, hang limit
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (ovf_out === 1'b1) ovf_n <= ovf_n + 1;
        if (wdog_out === 1'b1) wdog_n <= wdog_n + 1;
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic clks(input int c);
        repeat (c) @(posedge clk_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    // read, compare the masked data in the cycle after the strobe
    task automatic rd(input logic [7:0] a, e, m);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk(rdata_out & m, e);
    endtask
    // restart mid-period, cycles until the next overflow
    task automatic meas(input logic [7:0] v);
        k = ovf_n;
        wait (ovf_n > k);
        clks(128);
        k = ovf_n;
        wr(8'he3, v);
        n = cyc;
        wait (ovf_n > k);
        n = cyc - n;
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        resetn_in = 1'b0;
        supply_low_in = 1'b0;
        irq_en_in = 1'b0;
        irq_pend_in = 1'b0;
        addr_in = 8'h00;
        wdata_in = 8'h00;
        wr_in = 1'b0;
        rd_in = 1'b0;
        clks(2);
        resetn_in <= 1'b1;
        rd(8'hff, 8'h10, 8'hff);
        chk(hold_out, 8'h01);
        wait (hold_out === 1'b0);
        irq_en_in <= 1'b1;
        chk(vec_out, 8'h00);
        rd(8'hf0, 8'h02, 8'h02);
        chk(irq_out, 8'h00);
        wr(8'hf1, 8'h02);
        chk(irq_out, 8'h01);
        wr(8'hf0, 8'h02);
        chk(irq_out, 8'h00);
        wr(8'hf1, 8'h00);
        wr(8'hff, 8'h30);
        rd(8'hff, 8'h90, 8'hff);
        rd(8'h00, 8'h00, 8'hff);
        rd(8'he3, 8'h00, 8'hff);
        k = ovf_n;
        w = wdog_n;
        wait (ovf_n == k + 4);
        chk(8'(wdog_n - w), 8'h00);
        meas(8'h38);
        chk(8'(n >= 240), 8'h01);
        meas(8'h11);
        chk(8'(n < 200), 8'h01);
        // firmware picks the sleep period, then back to the short one
        wr(8'hf2, 8'h03);
        rd(8'hf2, 8'h03, 8'h03);
        wr(8'hf2, 8'h00);
        rd(8'hf2, 8'h00, 8'h03);
        // sleep, wake on pending interrupt, stop bit
        wr(8'hff, 8'h18);
        chk(sleep_out, 8'h01);
        @(posedge clk_in) irq_pend_in <= 1'b1;
        clks(2);
        #1 chk(sleep_out, 8'h00);
        @(posedge clk_in) irq_pend_in <= 1'b0;
        wr(8'hff, 8'h11);
        chk(stop_out, 8'h01);
        wr(8'hff, 8'h10);
        chk(stop_out, 8'h00);
        // enable watchdog, feed it, then let it expire
        wr(8'hff, 8'h00);
        rd(8'hff, 8'h80, 8'hff);
        w = wdog_n;
        for (int i = 0; i < 6; i++) begin
            clks(200);
            wr(8'he3, 8'(i * 37));
        end
        chk(8'(wdog_n - w), 8'h00);
        k = ovf_n;
        wait (wdog_n > w);
        chk(8'(ovf_n - k), 8'h03);
        rd(8'hff, 8'ha0, 8'hff);
        rd(8'hf1, 8'h00, 8'hff);
        w = wdog_n;
        wr(8'hff, 8'h30);
        rd(8'hff, 8'ha0, 8'hff);
        wait (wdog_n > w);
        chk(8'(wdog_n - w), 8'h01);
        // firmware clears the watchdog flag, then wait for the next expiry
        w = wdog_n;
        wr(8'hff, 8'h10);
        rd(8'hff, 8'h80, 8'hff);
        wait (wdog_n > w);
        // supply drop behaves as power-on, processor flags reset too
        @(posedge clk_in) supply_low_in <= 1'b1;
        irq_en_in <= 1'b0;
        clks(2);
        supply_low_in <= 1'b0;
        #1 chk(hold_out, 8'h01);
        rd(8'hff, 8'h10, 8'hff);
        final_report();
    end
endmodule
bind rwu_top rwu_top_asserts #(.HOLD_CYCLES(HOLD_CYCLES)) chk_u (
    .CLK_IN, .RESETN_IN, .SUPPLY_LOW_IN, .IRQ_PENDING_IN, .ADDR_IN,
    .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT, .CPU_HOLD_OUT,
    .RESET_VECTOR_OUT, .CPU_SLEEP_OUT, .CPU_STOP_OUT,
    .WATCHDOG_RESET_EVENT_OUT, .SLEEP_TIMER_IRQ_OUT, .IRQ_OUT);
